// File: spp_protect.sv
// Sector and password protection core of a serial NOR flash.
// Assumes a command decoder on clk hands over decoded commands, and the
// program/erase engine asks for a sector verdict before it touches memory.
// reset stands for power-up; dev_reset_req is the device reset pin.
`timescale 1ns/1ns
`include "spp_map.svh"
module spp_protect import spp_pkg::*; #(
  parameter int NSEC = `SPP_NSEC_DEF,
  parameter int NSUB = `SPP_NSUB_DEF,
  parameter int PW_W = `SPP_PW_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic dev_reset_req,
  input wire logic cmd_valid,
  input wire spp_op_t cmd_op,
  input wire logic [$clog2(NSEC)-1:0] cmd_sector,
  input wire logic [$clog2(NSUB)-1:0] cmd_sub,
  input wire logic [PW_W-1:0] cmd_data,
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [PW_W-1:0] rsp_data,
  input wire logic chk_valid,
  input wire logic [$clog2(NSEC)-1:0] chk_sector,
  input wire logic [$clog2(NSUB)-1:0] chk_sub,
  output logic chk_rsp_valid,
  output logic chk_allowed,
  output logic pw_mode_on,
  output logic freeze_on
);

  localparam int SW = $clog2(NSEC);
  localparam int UW = $clog2(NSUB);
  localparam int MW = `SPP_MODE_W;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [MW-1:0] mode;
    logic freeze;
    logic [PW_W-1:0] pw;
    logic [NSEC-1:0] nv_lock;
    logic [NSEC-1:0] v_wlock;
    logic [NSEC-1:0] v_ldown;
    logic [1:0][NSUB-1:0] sub_wlock;
    logic [1:0][NSUB-1:0] sub_ldown;
    logic rsp_valid;
    logic rsp_ok;
    logic [PW_W-1:0] rsp_data;
    logic chk_valid;
    logic chk_ok;
  } spp_state_t;

  spp_state_t s_r;
  spp_state_t s_nxt;

  logic dev_rst;
  logic pw_active;
  logic unlock_ok;
  logic [MW-1:0] mode_pgm;
  logic [1:0] cmd_edge;
  logic [1:0] chk_vbits;
  logic [1:0] cmd_vbits;
  logic chk_wlock;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Flags a first or last sector; bit 0 picks which
  function automatic logic [1:0] edge_sel(input logic [SW-1:0] sec);
    logic [1:0] r;
    r = 2'b00;
    if (sec == '0) begin
      r = 2'b10;
    end else if (sec == SW'(NSEC - 1)) begin
      r = 2'b11;
    end
    return r;
  endfunction : edge_sel

  // Volatile lock byte of a sector, or of a subsector in an edge sector
  function automatic logic [1:0] vbits(input spp_state_t st,
                                       input logic [SW-1:0] sec,
                                       input logic [UW-1:0] sub);
    logic [1:0] e;
    logic [1:0] r;
    e = edge_sel(sec);
    r = {st.v_ldown[sec], st.v_wlock[sec]};
    if (e[1]) begin
      r = {st.sub_ldown[e[0]][sub], st.sub_wlock[e[0]][sub]};
    end
    return r;
  endfunction : vbits

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign dev_rst = s_r.rst_sync[1];
  assign pw_active = ~s_r.mode[`SPP_MODE_PW_BIT];
  assign cmd_edge = edge_sel(cmd_sector);
  assign cmd_vbits = vbits(s_r, cmd_sector, cmd_sub);
  assign chk_vbits = vbits(s_r, chk_sector, chk_sub);
  assign chk_wlock = chk_vbits[`SPP_VLK_WL_BIT];
  // OTP programming only clears bits; reserved bits stay one
  assign mode_pgm = s_r.mode & (cmd_data[MW-1:0] | ~MW'(6));

  spp_pw_check #(
    .PW_W(PW_W)
  ) u_pw_check (
    .stored(s_r.pw),
    .supplied(cmd_data),
    .pw_mode_on(pw_active),
    .unlock_ok(unlock_ok)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rst_sync = {s_r.rst_sync[0], dev_reset_req};
    s_nxt.rsp_valid = 1'b0;
    s_nxt.rsp_ok = 1'b0;
    s_nxt.chk_valid = 1'b0;
    s_nxt.chk_ok = 1'b0;

    // Program/erase verdict for the engine
    if (chk_valid) begin
      s_nxt.chk_valid = 1'b1;
      s_nxt.chk_ok = s_r.nv_lock[chk_sector] && !chk_wlock;
    end

    if (cmd_valid) begin
      s_nxt.rsp_valid = 1'b1;
      s_nxt.rsp_data = '0;
      case (cmd_op)
        SPP_OP_RD_MODE: begin
          s_nxt.rsp_ok = 1'b1;
          s_nxt.rsp_data = PW_W'(s_r.mode);
        end
        SPP_OP_PGM_MODE: begin
          // Refuse any result with both mode bits at zero
          if (mode_pgm[`SPP_MODE_PW_BIT] || mode_pgm[`SPP_MODE_SP_BIT]) begin
            s_nxt.mode = mode_pgm;
            s_nxt.rsp_ok = 1'b1;
          end
        end
        SPP_OP_RD_PW: begin
          s_nxt.rsp_ok = !pw_active;
          s_nxt.rsp_data = pw_active ? PW_W'(`SPP_PW_HIDDEN) : s_r.pw;
        end
        SPP_OP_PGM_PW: begin
          if (!pw_active) begin
            s_nxt.pw = cmd_data;
            s_nxt.rsp_ok = 1'b1;
          end
        end
        SPP_OP_UNLOCK_PW: begin
          // Wrong password leaves freeze as it was
          if (unlock_ok) begin
            s_nxt.freeze = 1'b1;
            s_nxt.rsp_ok = 1'b1;
          end
        end
        SPP_OP_RD_FREEZE: begin
          s_nxt.rsp_ok = 1'b1;
          s_nxt.rsp_data = PW_W'(s_r.freeze);
        end
        SPP_OP_WR_FREEZE: begin
          s_nxt.freeze = 1'b0;
          s_nxt.rsp_ok = 1'b1;
        end
        SPP_OP_RD_NVLOCK: begin
          s_nxt.rsp_ok = 1'b1;
          s_nxt.rsp_data = PW_W'(s_r.nv_lock[cmd_sector]);
        end
        SPP_OP_WR_NVLOCK: begin
          // Mode bit 1 plays no part here
          if (s_r.freeze) begin
            s_nxt.nv_lock[cmd_sector] = 1'b0;
            s_nxt.rsp_ok = 1'b1;
          end
        end
        SPP_OP_ERASE_NVLOCK: begin
          if (s_r.freeze) begin
            s_nxt.nv_lock = '1;
            s_nxt.rsp_ok = 1'b1;
          end
        end
        SPP_OP_RD_VLOCK: begin
          s_nxt.rsp_ok = 1'b1;
          s_nxt.rsp_data = PW_W'(cmd_vbits);
        end
        SPP_OP_WR_VLOCK: begin
          if (!cmd_vbits[`SPP_VLK_LD_BIT]) begin
            s_nxt.rsp_ok = 1'b1;
            if (cmd_edge[1]) begin
              s_nxt.sub_wlock[cmd_edge[0]][cmd_sub] = cmd_data[`SPP_VLK_WL_BIT];
              s_nxt.sub_ldown[cmd_edge[0]][cmd_sub] = cmd_data[`SPP_VLK_LD_BIT];
            end else begin
              s_nxt.v_wlock[cmd_sector] = cmd_data[`SPP_VLK_WL_BIT];
              s_nxt.v_ldown[cmd_sector] = cmd_data[`SPP_VLK_LD_BIT];
            end
          end
        end
        default: begin
          s_nxt.rsp_ok = 1'b0;
        end
      endcase
    end

    // Device reset drops volatile state; password mode re-freezes
    if (dev_rst) begin
      s_nxt.v_wlock = '0;
      s_nxt.v_ldown = '0;
      s_nxt.sub_wlock = '0;
      s_nxt.sub_ldown = '0;
      s_nxt.freeze = s_r.mode[`SPP_MODE_PW_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Power-up gives the delivered state: all unlocked, freeze open
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.mode <= `SPP_MODE_RST;
      s_r.freeze <= `SPP_FREEZE_RST;
      s_r.pw <= PW_W'(`SPP_PW_RST);
      s_r.nv_lock <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rsp_valid = s_r.rsp_valid;
  assign rsp_ok = s_r.rsp_ok;
  assign rsp_data = s_r.rsp_data;
  assign chk_rsp_valid = s_r.chk_valid;
  assign chk_allowed = s_r.chk_ok;
  assign pw_mode_on = pw_active;
  assign freeze_on = s_r.freeze;

endmodule : spp_protect

// File: spp_map.svh
// Constants of the sector and password protection logic.
// Assumes inclusion by every design module that needs it; spp_pkg does not include it.
`ifndef SPP_MAP_SVH
`define SPP_MAP_SVH

// ---------------------------------------------------------------
// Geometry defaults
// ---------------------------------------------------------------
`define SPP_NSEC_DEF 512
`define SPP_NSUB_DEF 16
`define SPP_PW_W 64

// ---------------------------------------------------------------
// Protection-mode register
// ---------------------------------------------------------------
`define SPP_MODE_W 16
`define SPP_MODE_RST 16'hFFFF
`define SPP_MODE_PW_BIT 2
`define SPP_MODE_SP_BIT 1

// ---------------------------------------------------------------
// Freeze, password, volatile lock byte
// ---------------------------------------------------------------
`define SPP_FREEZE_RST 1'b1
`define SPP_PW_RST 64'hFFFF_FFFF_FFFF_FFFF
`define SPP_PW_HIDDEN 64'hFFFF_FFFF_FFFF_FFFF
`define SPP_VLK_WL_BIT 0
`define SPP_VLK_LD_BIT 1

`endif

// File: spp_pkg.sv
// Types shared by the sector and password protection logic.
// Assumes spp_map.svh is on the include path.
package spp_pkg;

  // Commands handed over by the serial command decoder
  typedef enum logic [3:0] {
    SPP_OP_RD_MODE,
    SPP_OP_PGM_MODE,
    SPP_OP_RD_PW,
    SPP_OP_PGM_PW,
    SPP_OP_UNLOCK_PW,
    SPP_OP_RD_FREEZE,
    SPP_OP_WR_FREEZE,
    SPP_OP_RD_NVLOCK,
    SPP_OP_WR_NVLOCK,
    SPP_OP_ERASE_NVLOCK,
    SPP_OP_RD_VLOCK,
    SPP_OP_WR_VLOCK
  } spp_op_t;

endpackage : spp_pkg

// File: spp_pw_check.sv
// Password comparator for the unlock command.
// Assumes stored and supplied words are stable in the cycle they are compared.
`timescale 1ns/1ns
module spp_pw_check import spp_pkg::*; #(
  parameter int PW_W = 64
) (
  input wire logic [PW_W-1:0] stored,
  input wire logic [PW_W-1:0] supplied,
  input wire logic pw_mode_on,
  output logic unlock_ok
);

  // ---------------------------------------------------------------
  // Compare
  // ---------------------------------------------------------------
  // Only a full match counts, and only while password mode is on
  always_comb begin
    unlock_ok = pw_mode_on && (stored == supplied);
  end

endmodule : spp_pw_check

// File: spp_protect_sva.sv
// Checker for spp_protect, bound to its ports.
// Assumes every command and check is answered one cycle after it is taken.
`timescale 1ns/1ns
module spp_protect_sva import spp_pkg::*; #(
  parameter int NSEC = 512,
  parameter int NSUB = 16,
  parameter int PW_W = 64
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic dev_reset_req,
  input wire logic cmd_valid,
  input wire spp_op_t cmd_op,
  input wire logic [PW_W-1:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic chk_valid,
  input wire logic chk_rsp_valid,
  input wire logic pw_mode_on,
  input wire logic freeze_on
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_rsp_timing: assert property (cmd_valid |=> rsp_valid)
    else $error("command not answered");
  a_chk_timing: assert property (chk_valid |=> chk_rsp_valid)
    else $error("check not answered");
  a_freeze_write: assert property (cmd_valid && cmd_op == SPP_OP_WR_FREEZE
    && !$past(dev_reset_req, 2) |=> rsp_ok && !freeze_on) else $error("freeze not cleared");
  a_nvlock_frozen: assert property (cmd_valid && !freeze_on && (cmd_op == SPP_OP_WR_NVLOCK
    || cmd_op == SPP_OP_ERASE_NVLOCK) |=> !rsp_ok) else $error("frozen lock changed");
  a_freeze_rise: assert property (pw_mode_on && !freeze_on
    && !(cmd_valid && cmd_op == SPP_OP_UNLOCK_PW) |=> !freeze_on) else $error("freeze rose");
  a_pw_frozen: assert property (cmd_valid && cmd_op == SPP_OP_PGM_PW && pw_mode_on |=> !rsp_ok)
    else $error("password changed");
  a_pw_sticky: assert property (pw_mode_on |=> pw_mode_on)
    else $error("password mode left");
  a_pw_hidden: assert property (cmd_valid && cmd_op == SPP_OP_RD_PW && pw_mode_on
    |=> !rsp_ok && rsp_data == '1) else $error("password exposed");
  a_mode_shape: assert property (cmd_valid && cmd_op == SPP_OP_RD_MODE
    |=> rsp_data[15:3] == '1 && rsp_data[0] && rsp_data[2:1] != 2'b00) else $error("bad mode");
  a_devrst_freeze: assert property ($past(dev_reset_req, 2) && pw_mode_on |=> !freeze_on)
    else $error("freeze open after reset");
endmodule : spp_protect_sva

bind spp_protect spp_protect_sva #(.NSEC(NSEC), .NSUB(NSUB), .PW_W(PW_W)) u_sva (
  .clk(clk), .reset(reset), .dev_reset_req(dev_reset_req), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
  .chk_valid(chk_valid), .chk_rsp_valid(chk_rsp_valid), .pw_mode_on(pw_mode_on),
  .freeze_on(freeze_on));

// File: spp_host.sv
// Host controller model driving commands and sector checks.
// Assumes 8 sectors of 4 subsectors and one-cycle answers.
`timescale 1ns/1ns
module spp_host import spp_pkg::*; (
  input wire logic clk,
  output logic cmd_valid,
  output spp_op_t cmd_op,
  output logic [2:0] cmd_sector,
  output logic [1:0] cmd_sub,
  output logic [63:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic [63:0] rsp_data,
  output logic chk_valid,
  output logic [2:0] chk_sector,
  output logic [1:0] chk_sub,
  input wire logic chk_rsp_valid,
  input wire logic chk_allowed
);
  logic got_v, got_ok, got_cv, got_al;
  logic [63:0] got_d;
  initial begin
    {cmd_valid, chk_valid, cmd_sector, cmd_sub, chk_sector, chk_sub} = '0;
    cmd_op = SPP_OP_RD_MODE;
    cmd_data = 64'h0;
  end
  // ----
  // Transfers
  // ----
  task automatic send(input spp_op_t op, input logic [2:0] s, input logic [1:0] u,
                      input logic [63:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_sector <= s;
    cmd_sub <= u;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_data <= ~d;
    #1;
    {got_v, got_ok, got_d} = {rsp_valid, rsp_ok, rsp_data};
  endtask : send
  task automatic ask(input logic [2:0] s, input logic [1:0] u);
    @(posedge clk);
    chk_valid <= 1'b1;
    chk_sector <= s;
    chk_sub <= u;
    @(posedge clk);
    chk_valid <= 1'b0;
    #1;
    {got_cv, got_al} = {chk_rsp_valid, chk_allowed};
  endtask : ask
endmodule : spp_host

// File: tb_sector_password_protection.sv
// Testbench for spp_protect with its host model.
// Assumes spp_protect_sva is bound in.
`timescale 1ns/1ns
module tb_sector_password_protection import spp_pkg::*;;
  logic clk, reset, dev_reset_req, cmd_valid, rsp_valid, rsp_ok, chk_valid, chk_rsp_valid;
  logic chk_allowed, pw_mode_on, freeze_on;
  spp_op_t cmd_op;
  logic [2:0] cmd_sector, chk_sector;
  logic [1:0] cmd_sub, chk_sub;
  logic [63:0] cmd_data, rsp_data;
  int miscompares, check_count;
  localparam logic [63:0] PW = 64'h0123_4567_89AB_CDEF;
  spp_protect #(.NSEC(8), .NSUB(4), .PW_W(64)) i_dut (.clk, .reset, .dev_reset_req,
    .cmd_valid, .cmd_op, .cmd_sector, .cmd_sub, .cmd_data, .rsp_valid, .rsp_ok, .rsp_data,
    .chk_valid, .chk_sector, .chk_sub, .chk_rsp_valid, .chk_allowed, .pw_mode_on, .freeze_on);
  spp_host i_host (.clk, .cmd_valid, .cmd_op, .cmd_sector, .cmd_sub, .cmd_data, .rsp_valid,
    .rsp_ok, .rsp_data, .chk_valid, .chk_sector, .chk_sub, .chk_rsp_valid, .chk_allowed);
  // ----
  // Helpers
  // ----
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic op(input spp_op_t o, input logic [2:0] s, input logic [1:0] u,
                    input logic [63:0] d, input logic eok);
    i_host.send(o, s, u, d);
    chk("rsp_valid", 64'h1, {63'h0, i_host.got_v});
    chk("rsp_ok", {63'h0, eok}, {63'h0, i_host.got_ok});
  endtask : op
  task automatic probe(input logic [2:0] s, input logic [1:0] u, input logic e);
    i_host.ask(s, u);
    chk("chk_rsp_valid", 64'h1, {63'h0, i_host.got_cv});
    chk("chk_allowed", {63'h0, e}, {63'h0, i_host.got_al});
  endtask : probe
  task automatic dreset();
    @(posedge clk) dev_reset_req <= 1'b1;
    repeat (4) @(posedge clk);
    dev_reset_req <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : dreset
  task automatic preset();
    @(posedge clk) reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
  endtask : preset
  // ----
  // Scenarios
  // ----
  task automatic t_defaults();
    op(SPP_OP_RD_MODE, 3'h0, 2'h0, 64'h0, 1'b1);
    chk("mode", 64'hFFFF, i_host.got_d);
    op(SPP_OP_RD_FREEZE, 3'h0, 2'h0, 64'h0, 1'b1);
    chk("freeze", 64'h1, i_host.got_d);
    op(SPP_OP_UNLOCK_PW, 3'h0, 2'h0, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
    op(SPP_OP_RD_NVLOCK, 3'h4, 2'h0, 64'h0, 1'b1);
    chk("nvlock", 64'h1, i_host.got_d);
    probe(3'h0, 2'h0, 1'b1);
    probe(3'h7, 2'h3, 1'b1);
  endtask : t_defaults
  task automatic t_nvlock();
    op(SPP_OP_WR_NVLOCK, 3'h3, 2'h0, 64'h0, 1'b1);
    probe(3'h3, 2'h0, 1'b0);
    probe(3'h2, 2'h0, 1'b1);
    op(SPP_OP_WR_FREEZE, 3'h0, 2'h0, 64'h0, 1'b1);
    chk("freeze_on", 64'h0, {63'h0, freeze_on});
    op(SPP_OP_ERASE_NVLOCK, 3'h0, 2'h0, 64'h0, 1'b0);
    probe(3'h3, 2'h0, 1'b0);
    dreset();
    chk("freeze_on", 64'h1, {63'h0, freeze_on});
    probe(3'h3, 2'h0, 1'b0);
    op(SPP_OP_ERASE_NVLOCK, 3'h0, 2'h0, 64'h0, 1'b1);
    probe(3'h3, 2'h0, 1'b1);
  endtask : t_nvlock
  task automatic t_vlock();
    op(SPP_OP_WR_VLOCK, 3'h0, 2'h2, 64'h1, 1'b1);
    probe(3'h0, 2'h2, 1'b0);
    probe(3'h0, 2'h1, 1'b1);
    op(SPP_OP_WR_VLOCK, 3'h5, 2'h0, 64'h2, 1'b1);
    op(SPP_OP_WR_VLOCK, 3'h5, 2'h0, 64'h1, 1'b0);
    op(SPP_OP_RD_VLOCK, 3'h5, 2'h0, 64'h0, 1'b1);
    chk("vlock", 64'h2, i_host.got_d);
    op(SPP_OP_WR_VLOCK, 3'h7, 2'h1, 64'h1, 1'b1);
    probe(3'h7, 2'h1, 1'b0);
    probe(3'h7, 2'h0, 1'b1);
    probe(3'h6, 2'h1, 1'b1);
    dreset();
    probe(3'h0, 2'h2, 1'b1);
    probe(3'h7, 2'h1, 1'b1);
    op(SPP_OP_RD_VLOCK, 3'h5, 2'h0, 64'h0, 1'b1);
    chk("vlock", 64'h0, i_host.got_d);
  endtask : t_vlock
  task automatic t_spbit();
    op(SPP_OP_PGM_MODE, 3'h0, 2'h0, 64'h5, 1'b1);
    op(SPP_OP_PGM_MODE, 3'h0, 2'h0, 64'hFFFB, 1'b0);
    op(SPP_OP_RD_MODE, 3'h0, 2'h0, 64'h0, 1'b1);
    chk("mode", 64'hFFFD, i_host.got_d);
    op(SPP_OP_WR_NVLOCK, 3'h1, 2'h0, 64'h0, 1'b1);
    probe(3'h1, 2'h0, 1'b0);
  endtask : t_spbit
  task automatic t_password();
    op(SPP_OP_PGM_PW, 3'h0, 2'h0, PW, 1'b1);
    op(SPP_OP_RD_PW, 3'h0, 2'h0, 64'h0, 1'b1);
    chk("password", PW, i_host.got_d);
    op(SPP_OP_PGM_MODE, 3'h0, 2'h0, 64'hFFFB, 1'b1);
    chk("pw_mode_on", 64'h1, {63'h0, pw_mode_on});
    op(SPP_OP_RD_PW, 3'h0, 2'h0, 64'h0, 1'b0);
    chk("password", 64'hFFFF_FFFF_FFFF_FFFF, i_host.got_d);
    op(SPP_OP_PGM_PW, 3'h0, 2'h0, ~PW, 1'b0);
    op(SPP_OP_PGM_MODE, 3'h0, 2'h0, 64'hFFFD, 1'b0);
    dreset();
    chk("freeze_on", 64'h0, {63'h0, freeze_on});
    op(SPP_OP_UNLOCK_PW, 3'h0, 2'h0, ~PW, 1'b0);
    chk("freeze_on", 64'h0, {63'h0, freeze_on});
    op(SPP_OP_WR_NVLOCK, 3'h2, 2'h0, 64'h0, 1'b0);
    op(SPP_OP_UNLOCK_PW, 3'h0, 2'h0, PW, 1'b1);
    op(SPP_OP_RD_FREEZE, 3'h0, 2'h0, 64'h0, 1'b1);
    chk("freeze", 64'h1, i_host.got_d);
    op(SPP_OP_WR_NVLOCK, 3'h2, 2'h0, 64'h0, 1'b1);
    probe(3'h2, 2'h0, 1'b0);
  endtask : t_password
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  // ----
  // Sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    conclude();
  end
  initial begin
    {reset, dev_reset_req} = 2'b10;
    preset();
    t_defaults();
    t_nvlock();
    t_vlock();
    t_spbit();
    preset();
    t_password();
    conclude();
  end
endmodule : tb_sector_password_protection
